/* hw/pmtr_access.sv */
// Program memory, vectors, table read and data memory map of the microcontroller.
`timescale 1ns/1ps
module pmtr_access
    import pmtr_pkg::*;
#(
    parameter int GP_DEPTH = PMTR_GP_DEPTH
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    output logic      [10:0] fetch_addr,
    output logic      [13:0] fetch_word,
    input  wire logic        pc_advance,
    input  wire logic        jump_valid,
    input  wire logic [10:0] jump_addr,
    input  wire logic        stack_full,
    output logic             int_ack,
    output logic      [10:0] int_return_addr,
    input  wire logic        ext_int_pin,
    input  wire logic        tmr0_overflow,
    input  wire logic        tmr1_overflow,
    input  wire logic        adc_done,
    input  wire logic        eeprom_write_done,
    input  wire logic        table_read_req,
    input  wire logic        table_read_last_page,
    input  wire logic  [6:0] table_read_dest,
    output logic             table_read_busy,
    output logic             table_read_done,
    input  wire logic        dm_rd,
    input  wire logic        dm_wr,
    input  wire logic        dm_bit_op,
    input  wire logic        dm_bit_value,
    input  wire logic  [2:0] dm_bit_index,
    input  wire logic  [6:0] dm_addr,
    input  wire logic  [7:0] dm_wdata,
    output logic       [7:0] dm_rdata,
    output logic       [7:0] eeprom_control,
    input  wire logic        icp_active,
    input  wire logic        icp_upload,
    input  wire logic        port_a_pin_zero_in,
    output logic             port_a_pin_zero_out,
    output logic             port_a_pin_zero_oe_b,
    input  wire logic        port_a_pin_four
);
    initial begin
        if (GP_DEPTH != 32'(8'h80) - 32'(A_GP_FIRST)) $error("General storage depth mismatch.");
    end

    pmtr_store_if sif ();
    pmtr_store u_store (.clk_sys(clk_sys), .sif(sif));

    // ****************************************************************
    // Program counter and vectors
    // ****************************************************************
    logic [10:0]           pc;
    logic [PMTR_INT_N-1:0] pending;
    logic [PMTR_INT_N-1:0] take_one;
    logic [10:0]           take_vec;
    logic [7:0]            intc;
    logic [7:0]            misc;
    logic                  take;
    logic                  pcl_write;
    logic [7:0]            pcl_value;

    localparam logic [10:0] VECTORS [PMTR_INT_N] = '{VEC_EXT, VEC_TMR0, VEC_TMR1, VEC_ADC, VEC_EE};

    // Fixed priority: the lowest index holds the lowest vector and wins.
    always_comb begin
        take_one = '0;
        take_vec = VEC_RESET;
        for (int i = PMTR_INT_N - 1; i >= 0; i--) begin
            if (pending[i]) begin
                take_one = PMTR_INT_N'(1) << i;
                take_vec = VECTORS[i];
            end
        end
    end

    // The ack waits on a free stack slot at an instruction boundary.
    assign take            = pc_advance && intc[INTC_GLOBAL] && (|pending) && !stack_full;
    assign int_ack         = take;
    assign int_return_addr = pc;
    assign fetch_addr      = pc;
    assign fetch_word      = sif.fetch_data;
    assign sif.fetch_addr  = pc;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pc <= VEC_RESET;
        end else if (take) begin
            pc <= take_vec;
        end else if (jump_valid) begin
            pc <= jump_addr;
        end else if (pcl_write) begin
            pc <= {pc[10:8], pcl_value};
        end else if (pc_advance) begin
            pc <= pc + 11'(1);
        end
    end

    // ****************************************************************
    // Interrupt requests
    // ****************************************************************
    logic                  ext_prev;
    logic                  ext_edge;
    logic [PMTR_INT_N-1:0] raw_event;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ext_prev <= 1'b1;
        end else begin
            ext_prev <= ext_int_pin;
        end
    end

    always_comb begin
        case (misc[1:0])
            EDGE_FALL: ext_edge = ext_prev && !ext_int_pin;
            EDGE_RISE: ext_edge = !ext_prev && ext_int_pin;
            EDGE_BOTH: ext_edge = ext_prev != ext_int_pin;
            default:   ext_edge = 1'b0;
        endcase
    end

    assign raw_event = {eeprom_write_done, adc_done, tmr1_overflow, tmr0_overflow, ext_edge};

    // A new event in the cycle its flag is taken is kept: set wins over clear.
    generate
        for (genvar g = 0; g < PMTR_INT_N; g++) begin : g_pend
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    pending[g] <= 1'b0;
                end else if (raw_event[g] && intc[INTC_EN_LSB + g]) begin
                    pending[g] <= 1'b1;
                end else if (take && take_one[g]) begin
                    pending[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Table read
    // ****************************************************************
    pmtr_tbl_state_t tbl_state;
    logic [7:0]      tblp;
    logic [7:0]      table_data_high;
    logic [10:0]     tbl_addr;
    logic [6:0]      tbl_dest;
    logic [10:0]     icp_addr;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tbl_state <= TBL_IDLE;
            tbl_addr  <= VEC_RESET;
            tbl_dest  <= A_IAR0;
        end else begin
            case (tbl_state)
                TBL_IDLE: begin
                    if (table_read_req) begin
                        tbl_state <= TBL_ADDR;
                        tbl_dest  <= table_read_dest;
                        tbl_addr  <= table_read_last_page ? {LAST_PAGE_HI, tblp}
                                                          : {pc[10:8], tblp};
                    end
                end
                TBL_ADDR: tbl_state <= TBL_DATA;
                TBL_DATA: tbl_state <= TBL_IDLE;
                default:  tbl_state <= TBL_IDLE;
            endcase
        end
    end

    assign table_read_busy = tbl_state != TBL_IDLE;
    assign table_read_done = tbl_state == TBL_DATA;
    assign sif.rd_addr     = icp_active ? icp_addr : tbl_addr;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            table_data_high <= REG_RESET;
        end else if (tbl_state == TBL_DATA) begin
            table_data_high <= 8'(sif.rd_data[PMTR_WORD_W-1:PMTR_DATA_W]);
        end
    end

    // ****************************************************************
    // Data memory map
    // ****************************************************************
    logic [7:0] gp_ram [GP_DEPTH];
    logic [7:0] mp0;
    logic [7:0] mp1;
    logic [7:0] bp;
    logic [6:0] eff_addr;
    logic       eff_bank1;
    logic       eff_null;
    logic [7:0] cur_value;
    logic [7:0] next_value;
    logic       wr_any;
    logic [6:0] wr_addr;
    logic       wr_bank1;
    logic       wr_null;
    logic [7:0] wr_data;
    logic       gp_hit;
    logic [6:0] gp_index;

    // Direct access is always bank 0; the first pointer never leaves bank 0.
    always_comb begin
        eff_addr  = dm_addr;
        eff_bank1 = 1'b0;
        eff_null  = 1'b0;
        if (dm_addr == A_IAR0) begin
            eff_addr = mp0[6:0];
            eff_null = (mp0[6:0] == A_IAR0) || (mp0[6:0] == A_IAR1);
        end else if (dm_addr == A_IAR1) begin
            eff_addr  = mp1[6:0];
            eff_bank1 = bp == BANK_ONE;
            eff_null  = (mp1[6:0] == A_IAR0) || (mp1[6:0] == A_IAR1);
        end
    end

    function automatic logic [7:0] read_loc(input logic [6:0] a, input logic bank1);
        logic [7:0] v;
        v = REG_RESET;
        if (bank1) begin
            if (a == A_EEPROM_CONTROL) v = eeprom_control;
        end else if (a >= A_GP_FIRST) begin
            v = gp_ram[7'(a - A_GP_FIRST)];
        end else begin
            case (a)
                A_MP0:   v = mp0 | 8'h80; // Unused top pointer bit reads as one.
                A_MP1:   v = mp1 | 8'h80;
                A_BP:    v = bp;
                A_PCL:   v = pc[7:0];
                A_TBLP:  v = tblp;
                A_TABLE_DATA_HIGH:  v = table_data_high;
                A_INTC:  v = intc;
                A_MISC:  v = misc;
                default: v = REG_RESET;
            endcase
        end
        return v;
    endfunction

    always_comb begin
        cur_value  = eff_null ? REG_RESET : read_loc(eff_addr, eff_bank1);
        next_value = dm_wdata;
        if (dm_bit_op) begin
            next_value = cur_value;
            next_value[dm_bit_index] = dm_bit_value;
        end
    end

    // A finishing table read owns the write port; the core waits on busy.
    always_comb begin
        if (tbl_state == TBL_DATA) begin
            wr_any   = 1'b1;
            wr_addr  = tbl_dest;
            wr_bank1 = 1'b0;
            wr_null  = 1'b0;
            wr_data  = sif.rd_data[7:0];
        end else begin
            wr_any   = dm_wr || dm_bit_op;
            wr_addr  = eff_addr;
            wr_bank1 = eff_bank1;
            wr_null  = eff_null;
            wr_data  = next_value;
        end
    end

    assign gp_hit    = wr_any && !wr_null && !wr_bank1 && (wr_addr >= A_GP_FIRST);
    assign gp_index  = 7'(wr_addr - A_GP_FIRST);
    assign pcl_write = wr_any && !wr_null && !wr_bank1 && (wr_addr == A_PCL);
    assign pcl_value = wr_data;

    always_ff @(posedge clk_sys) begin
        if (gp_hit) begin
            gp_ram[gp_index] <= wr_data;
        end
    end

    // Table-high has no write decode, so software writes to it are dropped.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mp0            <= REG_RESET;
            mp1            <= REG_RESET;
            bp             <= REG_RESET;
            tblp           <= REG_RESET;
            intc           <= REG_RESET;
            misc           <= REG_RESET;
            eeprom_control <= REG_RESET;
        end else if (wr_any && !wr_null) begin
            if (wr_bank1) begin
                if (wr_addr == A_EEPROM_CONTROL) eeprom_control <= wr_data;
            end else begin
                case (wr_addr)
                    A_MP0:   mp0  <= wr_data;
                    A_MP1:   mp1  <= wr_data;
                    A_BP:    bp   <= wr_data;
                    A_TBLP:  tblp <= wr_data;
                    A_INTC:  intc <= wr_data;
                    A_MISC:  misc <= wr_data;
                    default: mp0  <= mp0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dm_rdata <= REG_RESET;
        end else if (dm_rd) begin
            dm_rdata <= cur_value;
        end
    end

    // ****************************************************************
    // In-circuit programming port
    // ****************************************************************
    logic        clk_prev;
    logic        clk_rise;
    logic [13:0] icp_shift;
    logic [3:0]  icp_count;
    logic        icp_loaded;
    logic        icp_primed;

    assign clk_rise             = icp_active && port_a_pin_four && !clk_prev;
    assign port_a_pin_zero_out  = icp_shift[0];
    assign port_a_pin_zero_oe_b = !(icp_active && icp_upload);
    assign sif.wr_en            = clk_rise && !icp_upload && (icp_count == ICP_WORD_BITS - 4'(1));
    assign sif.wr_addr          = icp_addr;
    assign sif.wr_data          = {port_a_pin_zero_in, icp_shift[13:1]};

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            clk_prev   <= 1'b0;
            icp_shift  <= '0;
            icp_count  <= '0;
            icp_addr   <= VEC_RESET;
            icp_loaded <= 1'b0;
            icp_primed <= 1'b0;
        end else if (!icp_active) begin
            clk_prev   <= 1'b0;
            icp_count  <= '0;
            icp_addr   <= VEC_RESET;
            icp_loaded <= 1'b0;
            icp_primed <= 1'b0;
        end else begin
            clk_prev <= port_a_pin_four;
            // The store answers an edge after its address moves, so the load waits one edge.
            if (icp_upload && !icp_primed) begin
                icp_primed <= 1'b1;
            end else if (icp_upload && !icp_loaded) begin
                icp_shift  <= sif.rd_data;
                icp_loaded <= 1'b1;
            end else if (clk_rise) begin
                icp_shift <= {port_a_pin_zero_in, icp_shift[13:1]};
                if (icp_count == ICP_WORD_BITS - 4'(1)) begin
                    icp_count  <= '0;
                    icp_addr   <= icp_addr + 11'(1);
                    icp_loaded <= 1'b0;
                    icp_primed <= 1'b0;
                end else begin
                    icp_count <= icp_count + 4'(1);
                end
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_reset_vector: assert property (@(posedge clk_sys) $rose(rst_b) |-> pc == VEC_RESET)
        else $error("Counter not at reset vector after reset.");
    a_ext_vector: assert property (@(posedge clk_sys) disable iff (!rst_b)
        take && take_one[0] |=> pc == VEC_EXT)
        else $error("External interrupt did not reach its vector.");
    a_full_blocks: assert property (@(posedge clk_sys) disable iff (!rst_b)
        stack_full |-> !int_ack)
        else $error("Interrupt taken with a full stack.");
    a_pending_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (|pending) && stack_full |=> (|pending))
        else $error("Blocked interrupt was lost.");
    a_priority_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
        take && pending[0] |=> pc == VEC_EXT)
        else $error("Lowest vector did not win.");
    a_table_two: assert property (@(posedge clk_sys) disable iff (!rst_b)
        tbl_state == TBL_IDLE && table_read_req |=> table_read_busy ##1 table_read_done
        ##1 !table_read_busy)
        else $error("Table read did not take two cycles.");
    a_last_page: assert property (@(posedge clk_sys) disable iff (!rst_b)
        tbl_state == TBL_IDLE && table_read_req && table_read_last_page
        |=> tbl_addr == {LAST_PAGE_HI, $past(tblp)})
        else $error("Last-page address wrong.");
    a_table_data_high_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $past(tbl_state) != TBL_DATA |-> $stable(table_data_high))
        else $error("Table-high changed outside a table read.");
    a_bank_one: assert property (@(posedge clk_sys) disable iff (!rst_b)
        dm_rd && dm_addr == A_IAR1 && bp == BANK_ONE && mp1[6:0] != A_EEPROM_CONTROL
        |=> dm_rdata == REG_RESET)
        else $error("Bank 1 returned data outside its only register.");
endmodule // pmtr_access

/* common/pmtr_pkg.sv */
// Constants, types and the data memory map of the program memory access block.
package pmtr_pkg;
    localparam int          PMTR_PC_W      = 11;
    localparam int          PMTR_WORD_W    = 14;
    localparam int          PMTR_DATA_W    = 8;
    localparam int          PMTR_DM_W      = 7;
    localparam int          PMTR_INT_N     = 5;
    localparam int          PMTR_GP_DEPTH  = 88;
    // Program memory vectors.
    localparam logic [10:0] VEC_RESET      = 11'h000;
    localparam logic [10:0] VEC_EXT        = 11'h004;
    localparam logic [10:0] VEC_TMR0       = 11'h008;
    localparam logic [10:0] VEC_TMR1       = 11'h00C;
    localparam logic [10:0] VEC_ADC        = 11'h010;
    localparam logic [10:0] VEC_EE         = 11'h014;
    localparam logic [2:0]  LAST_PAGE_HI   = 3'h7;
    // Data memory map, bank 0 except A_EEPROM_CONTROL, which is in bank 1.
    localparam logic [6:0]  A_IAR0         = 7'h00;
    localparam logic [6:0]  A_MP0          = 7'h01;
    localparam logic [6:0]  A_IAR1         = 7'h02;
    localparam logic [6:0]  A_MP1          = 7'h03;
    localparam logic [6:0]  A_BP           = 7'h04;
    localparam logic [6:0]  A_PCL          = 7'h06;
    localparam logic [6:0]  A_TBLP         = 7'h07;
    localparam logic [6:0]  A_TABLE_DATA_HIGH         = 7'h08;
    localparam logic [6:0]  A_INTC         = 7'h0B;
    localparam logic [6:0]  A_MISC         = 7'h1F;
    localparam logic [6:0]  A_GP_FIRST     = 7'h28;
    localparam logic [6:0]  A_EEPROM_CONTROL       = 7'h40;
    // Field layout.
    localparam int          INTC_GLOBAL    = 0;
    localparam int          INTC_EN_LSB    = 1;
    localparam int          MP_TOP_BIT     = 7;
    localparam logic [1:0]  EDGE_FALL      = 2'h1;
    localparam logic [1:0]  EDGE_RISE      = 2'h2;
    localparam logic [1:0]  EDGE_BOTH      = 2'h3;
    localparam logic [7:0]  REG_RESET      = 8'h00;
    localparam logic [7:0]  BANK_ONE       = 8'h01;
    localparam logic [3:0]  ICP_WORD_BITS  = 4'hE;

    typedef enum logic [2:0] {
        TBL_IDLE = 3'b001,
        TBL_ADDR = 3'b010,
        TBL_DATA = 3'b100
    } pmtr_tbl_state_t;
endpackage

/* common/pmtr_store_if.sv */
// Connection between the access logic and the program store.
`timescale 1ns/1ps
interface pmtr_store_if;
    logic [10:0] fetch_addr;
    logic [13:0] fetch_data;
    logic [10:0] rd_addr;
    logic [13:0] rd_data;
    logic        wr_en;
    logic [10:0] wr_addr;
    logic [13:0] wr_data;
    modport access (output fetch_addr, output rd_addr, output wr_en, output wr_addr,
                    output wr_data, input fetch_data, input rd_data);
    modport store  (input fetch_addr, input rd_addr, input wr_en, input wr_addr,
                    input wr_data, output fetch_data, output rd_data);
endinterface

/* hw/pmtr_store.sv */
// Program store: 2K words of 14 bits with a fetch port, a read port and a write port.
`timescale 1ns/1ps
module pmtr_store
    import pmtr_pkg::*;
#(
    parameter int WORDS = 2048
) (
    input  wire logic clk_sys,
    pmtr_store_if.store sif
);
    initial begin
        if (WORDS != (1 << PMTR_PC_W)) $error("Store depth must match the address width.");
    end

    logic [PMTR_WORD_W-1:0] mem [WORDS];

    // No reset: the array models nonvolatile cells, so contents survive a device reset.
    always_ff @(posedge clk_sys) begin
        if (sif.wr_en) begin
            mem[sif.wr_addr] <= sif.wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        sif.fetch_data <= mem[sif.fetch_addr];
        sif.rd_data    <= mem[sif.rd_addr];
    end
endmodule // pmtr_store

/* testbench/pmtr_core_model.sv */
// Behavioural core model driving fetch advances, jumps and table reads.
`timescale 1ns/1ps
module pmtr_core_model (
    input  wire logic        clk_sys,
    input  wire logic        int_ack,
    output logic             pc_advance,
    output logic             jump_valid,
    output logic      [10:0] jump_addr,
    output logic             table_read_req,
    output logic             table_read_last_page,
    output logic       [6:0] table_read_dest
);
    initial begin
        {pc_advance, jump_valid, table_read_req, table_read_last_page} = 4'h0;
        jump_addr       = 11'h000;
        table_read_dest = 7'h00;
    end
    // The acknowledge is combinational, so it is taken mid-cycle while the advance stands.
    task automatic step(output logic ack);
        @(posedge clk_sys);
        pc_advance <= 1'b1;
        @(negedge clk_sys);
        ack = int_ack;
        @(posedge clk_sys);
        pc_advance <= 1'b0;
    endtask
    task automatic jump(input logic [10:0] a);
        @(posedge clk_sys);
        jump_valid <= 1'b1;
        jump_addr  <= a;
        @(posedge clk_sys);
        jump_valid <= 1'b0;
    endtask
    task automatic tread(input logic lp, input logic [6:0] d);
        @(posedge clk_sys);
        table_read_req       <= 1'b1;
        table_read_last_page <= lp;
        table_read_dest      <= d;
        @(posedge clk_sys);
        table_read_req <= 1'b0;
    endtask
endmodule // pmtr_core_model

/* testbench/tb_top.sv */
// Self-checking bench for the program memory access block.
`timescale 1ns/1ps
module tb_top;
    import pmtr_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_b, stack_full, ext_int_pin, tmr0_overflow, tmr1_overflow, adc_done;
    logic        eeprom_write_done, dm_rd, dm_wr, dm_bit_op, dm_bit_value, icp_active;
    logic        icp_upload, port_a_pin_four, pin0_drv, int_ack, table_read_busy, ack;
    logic        table_read_done, port_a_pin_zero_out, port_a_pin_zero_oe_b, pc_advance;
    logic        jump_valid, table_read_req, table_read_last_page;
    logic  [2:0] dm_bit_index;
    logic  [6:0] dm_addr, table_read_dest;
    logic  [7:0] dm_wdata, dm_rdata, eeprom_control;
    logic [10:0] fetch_addr, int_return_addr, jump_addr;
    logic [13:0] fetch_word;
    logic [13:0] tbl[8], w14;
    logic  [7:0] gp[128];
    logic [10:0] vec[5] = '{VEC_EXT, VEC_TMR0, VEC_TMR1, VEC_ADC, VEC_EE};
    int          miscompares = 0;
    int          check_count = 0;
    int          a;
    wire         port_a_pin_zero_in = port_a_pin_zero_oe_b ? pin0_drv : port_a_pin_zero_out;
    pmtr_access dut (.*);
    pmtr_core_model core (.*);
    always #25 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Kind bits are read, write, bit operation; data bits 3..0 double as bit value and index.
    task automatic dop(input logic [2:0] k, input logic [6:0] ad, input logic [7:0] v);
        @(posedge clk_sys);
        {dm_rd, dm_wr, dm_bit_op} <= k;
        dm_addr      <= ad;
        dm_wdata     <= v;
        dm_bit_index <= v[2:0];
        dm_bit_value <= v[3];
        @(posedge clk_sys);
        {dm_rd, dm_wr, dm_bit_op} <= 3'h0;
    endtask
    task automatic dchk(input logic [6:0] ad, input logic [7:0] e);
        dop(3'h4, ad, 8'h00);
        @(negedge clk_sys);
        chk("dm_rdata", 14'(e), 14'(dm_rdata));
    endtask
    task automatic fire(input logic [4:0] m);
        @(posedge clk_sys);
        ext_int_pin <= !m[0];
        {eeprom_write_done, adc_done, tmr1_overflow, tmr0_overflow} <= m[4:1];
        @(posedge clk_sys);
        ext_int_pin <= 1'b1;
        {eeprom_write_done, adc_done, tmr1_overflow, tmr0_overflow} <= 4'h0;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic icp_word(input logic [13:0] w);
        for (int i = 0; i < 14; i++) begin
            @(posedge clk_sys);
            pin0_drv        <= w[i];
            port_a_pin_four <= 1'b0;
            @(posedge clk_sys);
            port_a_pin_four <= 1'b1;
        end
        @(posedge clk_sys);
    endtask
    task automatic tcheck(input int p, input logic lp, input logic [13:0] e);
        dop(3'h2, A_TBLP, 8'(p));
        core.tread(lp, A_GP_FIRST);
        @(negedge clk_sys);
        chk("busy_done", 14'h2, 14'({table_read_busy, table_read_done}));
        @(negedge clk_sys);
        chk("busy_done", 14'h3, 14'({table_read_busy, table_read_done}));
        @(posedge clk_sys);
        dchk(A_GP_FIRST, e[7:0]);
        dchk(A_TABLE_DATA_HIGH, {2'h0, e[13:8]});
    endtask
    initial begin
        #3_000_000;
        miscompares++;
        test_done();
    end
    initial begin
        {rst_b, stack_full, tmr0_overflow, tmr1_overflow, adc_done, eeprom_write_done} = 6'h00;
        {dm_rd, dm_wr, dm_bit_op, dm_bit_value, icp_active, icp_upload, port_a_pin_four} = 7'h00;
        {ext_int_pin, pin0_drv} = 2'h3;
        {dm_bit_index, dm_addr, dm_wdata} = 18'h00000;
        void'($urandom(16));
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(negedge clk_sys);
        chk("fetch_addr", 14'(VEC_RESET), 14'(fetch_addr));
        chk("eeprom_control", 14'h0000, 14'(eeprom_control));
        $display("reset test done");
        @(posedge clk_sys);
        icp_active <= 1'b1;
        // Fill up to the last page so that both table pages hold known words.
        for (int w = 0; w < 32'h704; w++) begin
            w14 = 14'($urandom);
            if (w < 4) tbl[w] = w14;
            if (w >= 32'h700) tbl[w - 32'h6FC] = w14;
            icp_word(w14);
        end
        icp_active      <= 1'b0;
        port_a_pin_four <= 1'b0;
        core.jump(11'h001);
        repeat (2) @(negedge clk_sys);
        chk("fetch_word", tbl[1], fetch_word);
        core.jump(11'h0C3);
        tcheck(2, 1'b0, tbl[2]);
        core.jump(11'h7C3);
        tcheck(3, 1'b0, tbl[7]);
        core.jump(11'h0C3);
        tcheck(3, 1'b1, tbl[7]);
        dop(3'h2, A_TABLE_DATA_HIGH, 8'hFF);
        dchk(A_TABLE_DATA_HIGH, {2'h0, tbl[7][13:8]});
        $display("table test done");
        dchk(7'h09, 8'h00);
        for (int i = 0; i < 6; i++) begin
            a = 40 + $urandom % 88;
            gp[a] = 8'($urandom);
            dop(3'h2, 7'(a), gp[a]);
            dchk(7'(a), gp[a]);
        end
        dop(3'h1, 7'(a), {4'h0, ~gp[a][5], 3'h5});
        gp[a][5] = ~gp[a][5];
        dchk(7'(a), gp[a]);
        dop(3'h2, A_MP0, 8'(a));
        dchk(A_IAR0, gp[a]);
        dchk(A_MP0, 8'(a) | 8'h80);
        dop(3'h2, A_BP, BANK_ONE);
        dop(3'h2, A_MP1, 8'h40);
        dop(3'h2, A_IAR1, 8'h5A);
        dchk(A_IAR1, 8'h5A);
        chk("eeprom_control", 14'h5A, 14'(eeprom_control));
        dop(3'h2, A_MP1, 8'h41);
        dchk(A_IAR1, 8'h00);
        dop(3'h2, A_BP, REG_RESET);
        dop(3'h2, A_IAR1, 8'h33);
        dchk(7'h41, 8'h33);
        chk("eeprom_control", 14'h5A, 14'(eeprom_control));
        $display("data memory test done");
        dop(3'h2, A_MISC, 8'(EDGE_FALL));
        for (int k = 0; k < 5; k++) begin
            dop(3'h2, A_INTC, 8'h01 | 8'(2 << k));
            fire(5'(1 << k));
            chk("ret_addr", 14'(k == 0 ? 11'h0C3 : vec[k-1]), 14'(int_return_addr));
            core.step(ack);
            @(negedge clk_sys);
            chk("vector", 14'(vec[k]), 14'(fetch_addr));
        end
        dop(3'h2, A_MISC, 8'(EDGE_RISE));
        dop(3'h2, A_INTC, 8'h03);
        ext_int_pin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        core.step(ack);
        chk("int_ack", 14'h0, 14'(ack));
        ext_int_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        core.step(ack);
        chk("int_ack", 14'h1, 14'(ack));
        dop(3'h2, A_INTC, 8'h3F);
        stack_full <= 1'b1;
        fire(5'h0C);
        core.step(ack);
        chk("int_ack", 14'h0, 14'(ack));
        stack_full <= 1'b0;
        core.step(ack);
        @(negedge clk_sys);
        chk("vector", 14'(VEC_TMR1), 14'(fetch_addr));
        dop(3'h2, A_INTC, 8'h3F);
        core.step(ack);
        @(negedge clk_sys);
        chk("vector", 14'(VEC_ADC), 14'(fetch_addr));
        $display("interrupt test done");
        @(posedge clk_sys);
        icp_active <= 1'b1;
        icp_upload <= 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("oe_b", 14'h0, 14'(port_a_pin_zero_oe_b));
        for (int i = 0; i < 14; i++) begin
            chk("pin_zero_out", 14'(tbl[0][i]), 14'(port_a_pin_zero_out));
            @(posedge clk_sys);
            port_a_pin_four <= 1'b1;
            @(posedge clk_sys);
            port_a_pin_four <= 1'b0;
            @(negedge clk_sys);
        end
        $display("upload test done");
        test_done();
    end
endmodule // tb_top
